//--- rtl/sadc_pkg.sv
/*
 * constants, register map and carrier types of the sar converter controller.
 * assumes a classic wishbone master and a sar core that answers done with data.
 */
// Function
// - software, pin or pwm starts a conversion
// - four adc clocks per sample, adc clock capped
// - fifo mode buffers sixteen results
// - optional result view shifted left four bits
// - shunt mode converts a channel pair
// - pwm sequence mode converts one fixed channel
// - clearing start bit aborts to idle
// - eleven channels: eight pins, bandgap, temp, supply
// - adc clock is pclk over prescale plus one
// - result goes to data register or fifo
// - done flag set, interrupt when enabled
// - start bit reads one until conversion ends
// - single mode takes lowest enabled channel
// - hw enable and source 00 select pin
// - edge select picks rising or falling pin edge
// - pin deglitched, pulses under four clocks ignored
// - hw enable and source 11 select pwm
// - eight-bit delay after pwm trigger
// - two monitors, each watching one channel
// - match counter advances on threshold condition
// - compare runs on each monitored result
// - mismatch zeroes counter; count reached sets flag
// - dma request at eight fifo entries
package sadc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int ADC_CLK_MAX_MHZ = 32;
    localparam int ADC_MIN_DIV = (CLK_MHZ + ADC_CLK_MAX_MHZ - 1) / ADC_CLK_MAX_MHZ;
    localparam int SAMPLE_TICKS = 4;
    localparam int DEGLITCH_CYC = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int DMA_LEVEL = 8;
    localparam int NUM_CH = 11;
    // byte offsets of the register words
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CTL = 8'h20;
    localparam logic [7:0] OFS_CHEN = 8'h24;
    localparam logic [7:0] OFS_CMP0 = 8'h28;
    localparam logic [7:0] OFS_CMP1 = 8'h2C;
    localparam logic [7:0] OFS_STAT = 8'h30;
    localparam logic [7:0] OFS_DLY = 8'h44;
    localparam logic [7:0] OFS_SEQ = 8'h4C;
    localparam logic [7:0] OFS_SEQ1 = 8'h50;
    localparam logic [7:0] OFS_SEQ2 = 8'h54;
    localparam logic [7:0] OFS_CTL2 = 8'h58;
    localparam logic [7:0] OFS_LS = 8'h5C;
    localparam logic [7:0] OFS_FCTL = 8'h68;
    localparam logic [7:0] OFS_POP = 8'h70;
    // field positions
    localparam int CTL_IE = 1;
    localparam int CTL_SRC = 4;
    localparam int CTL_EDGE = 6;
    localparam int CTL_HWEN = 8;
    localparam int CTL_START = 11;
    localparam int CMP_IE = 0;
    localparam int CMP_COND = 2;
    localparam int CMP_CH = 3;
    localparam int CMP_MCNT = 8;
    localparam int CMP_THR = 16;
    localparam int SEQ_EN = 0;
    localparam int SEQ_ONE = 1;
    localparam int SEQ_PAIR = 2;
    localparam int SEQ_CHF = 8;
    localparam int CTL2_DIV = 8;
    localparam int DAT_OVR = 16;
    localparam int DAT_VLD = 17;
    localparam int LS_VAL = 16;
    localparam int STAT_BUSY = 3;
    localparam int STAT_CNT = 8;
    localparam logic [1:0] SRC_PIN = 2'b00;
    localparam logic [1:0] SRC_PWM = 2'b11;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sadc_wb_req_t;

    typedef struct packed {
        logic sclk;
        logic sample;
        logic convert;
        logic [3:0] channel;
    } sadc_sar_req_t;

    typedef struct packed {
        logic ie;
        logic cond;
        logic [3:0] ch;
        logic [3:0] mcnt;
        logic [11:0] thr;
    } sadc_cmp_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } sadc_state_t;
endpackage

//--- rtl/sadc_ctrl.sv
/*
 * sar converter controller: wishbone registers, start sources, mode
 * sequencing, result data register and fifo, two compare monitors.
 * assumes synchronous inputs and a sar core that pulses done with data.
 */
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl #(
    parameter int DEPTH = sadc_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire sadc_pkg::sadc_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic external_start_pin_i,
    input wire logic pwm_trig_i,
    input wire logic sar_done_i,
    input wire logic [11:0] sar_result_i,
    output sadc_pkg::sadc_sar_req_t sar_o,
    output logic irq_o,
    output logic dma_req_o
);
    import sadc_pkg::*;
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic start;
        logic irq_en;
        logic hw_en;
        logic [1:0] src;
        logic edge_rise;
        logic [NUM_CH-1:0] chen;
        sadc_cmp_t [1:0] cmp;
        logic [1:0][4:0] mrun;
        logic done_f;
        logic [1:0] cmp_f;
        logic [7:0] dly;
        logic seq_en;
        logic one_ch;
        logic [1:0] pair;
        logic [2:0] seq_ch;
        logic [2:0] div;
        logic fifo_en;
        logic dma_en;
        logic ls_en;
        logic [11:0] res;
        logic vld;
        logic ovr;
        logic [11:0] seq1;
        logic [11:0] seq2;
        logic [15:0] ls_val;
        logic [DEPTH-1:0][11:0] fifo;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [2:0] pdiv;
        logic sclk;
        sadc_state_t st;
        logic [1:0] smp;
        logic second;
        logic [3:0] ch;
        logic [2:0] stab;
        logic filt;
        logic [7:0] dcnt;
        logic drun;
    } sadc_st_t;

    sadc_st_t s_q, s_d;

    // lowest enabled channel, or all ones when none is enabled
    function automatic logic [3:0] lowest(input logic [NUM_CH-1:0] en);
        lowest = 4'hF;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (en[i]) begin
                lowest = 4'(i);
            end
        end
    endfunction
    // byte-lane merge of a write onto the current word
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            o[b*8 +: 8] = sel[b] ? n[b*8 +: 8] : o[b*8 +: 8];
        end
        merge = o;
    endfunction
    // first and second channel of a shunt pair
    function automatic logic [3:0] pair_ch(input logic [1:0] p, input logic second);
        case (p)
            2'b00: pair_ch = second ? 4'h1 : 4'h0;
            2'b01: pair_ch = second ? 4'h2 : 4'h1;
            default: pair_ch = second ? 4'h2 : 4'h0;
        endcase
    endfunction
    logic acc, rd, wr, tick, pin_edge, go, res_take, busy;
    logic [2:0] eff_div;
    logic [31:0] rv, wv, clr;
    logic [3:0] first_ch;
    // register view, also the base that partial writes merge onto
    always_comb begin
        rv = RST_WORD;
        case (wb_req_i.adr)
            OFS_DATA: rv = {14'h0000, s_q.vld, s_q.ovr, 4'h0, s_q.res};
            OFS_CTL: begin
                rv[CTL_IE] = s_q.irq_en;
                rv[CTL_SRC +: 2] = s_q.src;
                rv[CTL_EDGE] = s_q.edge_rise;
                rv[CTL_HWEN] = s_q.hw_en;
                rv[CTL_START] = s_q.start;
            end
            OFS_CHEN: rv[NUM_CH-1:0] = s_q.chen;
            OFS_CMP0: rv = {4'h0, s_q.cmp[0].thr, 4'h0, s_q.cmp[0].mcnt, 1'b0, s_q.cmp[0].ch,
                            s_q.cmp[0].cond, 1'b0, s_q.cmp[0].ie};
            OFS_CMP1: rv = {4'h0, s_q.cmp[1].thr, 4'h0, s_q.cmp[1].mcnt, 1'b0, s_q.cmp[1].ch,
                            s_q.cmp[1].cond, 1'b0, s_q.cmp[1].ie};
            OFS_STAT: begin
                rv[2:0] = {s_q.cmp_f, s_q.done_f};
                rv[STAT_BUSY] = busy;
                rv[STAT_CNT +: AW+1] = s_q.cnt;
            end
            OFS_DLY: rv[7:0] = s_q.dly;
            OFS_SEQ: begin
                rv[SEQ_EN] = s_q.seq_en;
                rv[SEQ_ONE] = s_q.one_ch;
                rv[SEQ_PAIR +: 2] = s_q.pair;
                rv[SEQ_CHF +: 3] = s_q.seq_ch;
            end
            OFS_SEQ1: rv[11:0] = s_q.seq1;
            OFS_SEQ2: rv[11:0] = s_q.seq2;
            OFS_CTL2: rv[CTL2_DIV +: 3] = s_q.div;
            OFS_LS: rv = {s_q.ls_val, 15'h0000, s_q.ls_en};
            OFS_FCTL: rv[1:0] = {s_q.dma_en, s_q.fifo_en};
            OFS_POP: rv[11:0] = (s_q.cnt != '0) ? s_q.fifo[s_q.rp] : 12'h000;
            default: rv = RST_WORD;
        endcase
    end
    assign acc = wb_req_i.cyc && wb_req_i.stb && !s_q.ack;
    assign rd = acc && !wb_req_i.we;
    assign wr = acc && wb_req_i.we;
    assign wv = merge(rv, wb_req_i.dat, wb_req_i.sel);
    assign clr = merge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);
    assign busy = (s_q.st != ST_IDLE);
    // divisor is held at the least that keeps the adc clock at or under its cap
    assign eff_div = (s_q.div < 3'(ADC_MIN_DIV - 1)) ? 3'(ADC_MIN_DIV - 1) : s_q.div;
    assign tick = (s_q.pdiv == eff_div);
    assign first_ch = (s_q.seq_en && s_q.one_ch) ? {1'b0, s_q.seq_ch}
                    : s_q.seq_en ? pair_ch(s_q.pair, 1'b0) : lowest(s_q.chen);
    assign res_take = (s_q.st == ST_CONVERT) && sar_done_i;
    always_comb begin
        s_d = s_q;
        go = 1'b0;
        pin_edge = 1'b0;
        s_d.ack = acc;
        if (rd) begin
            s_d.rdat = rv;
        end
        // prescaler runs free, so the first adc period of a sample window can be a partial one
        s_d.pdiv = tick ? 3'h0 : s_q.pdiv + 3'h1;
        s_d.sclk = (s_d.pdiv > (eff_div >> 1));
        // pin deglitch: a new level must stand for four clocks before it counts
        if (external_start_pin_i == s_q.filt) begin
            s_d.stab = 3'h0;
        end else if (s_q.stab == 3'(DEGLITCH_CYC - 1)) begin
            s_d.stab = 3'h0;
            s_d.filt = external_start_pin_i;
            pin_edge = (external_start_pin_i == s_q.edge_rise);
        end else begin
            s_d.stab = s_q.stab + 3'h1;
        end
        // register writes
        if (wr) begin
            case (wb_req_i.adr)
                OFS_CTL: begin
                    s_d.irq_en = wv[CTL_IE];
                    s_d.src = wv[CTL_SRC +: 2];
                    s_d.edge_rise = wv[CTL_EDGE];
                    s_d.hw_en = wv[CTL_HWEN];
                    s_d.start = wv[CTL_START];
                    go = wv[CTL_START] && !busy;
                    if (!wv[CTL_START]) begin
                        s_d.st = ST_IDLE;
                        s_d.drun = 1'b0;
                    end
                end
                OFS_CHEN: s_d.chen = wv[NUM_CH-1:0];
                OFS_CMP0: s_d.cmp[0] = {wv[CMP_IE], wv[CMP_COND], wv[CMP_CH +: 4], wv[CMP_MCNT +: 4],
                                        wv[CMP_THR +: 12]};
                OFS_CMP1: s_d.cmp[1] = {wv[CMP_IE], wv[CMP_COND], wv[CMP_CH +: 4], wv[CMP_MCNT +: 4],
                                        wv[CMP_THR +: 12]};
                OFS_STAT: begin
                    s_d.done_f = s_q.done_f && !clr[0];
                    s_d.cmp_f = s_q.cmp_f & ~clr[2:1];
                end
                OFS_DLY: s_d.dly = wv[7:0];
                OFS_SEQ: begin
                    s_d.seq_en = wv[SEQ_EN];
                    s_d.one_ch = wv[SEQ_ONE];
                    s_d.pair = wv[SEQ_PAIR +: 2];
                    s_d.seq_ch = wv[SEQ_CHF +: 3];
                end
                OFS_CTL2: s_d.div = wv[CTL2_DIV +: 3];
                OFS_LS: s_d.ls_en = wv[0];
                OFS_FCTL: {s_d.dma_en, s_d.fifo_en} = wv[1:0];
                default: ;
            endcase
        end
        // read side effects: data read drops valid, pop read frees an entry
        if (rd && wb_req_i.adr == OFS_DATA) begin
            s_d.vld = 1'b0;
            s_d.ovr = 1'b0;
        end
        if (rd && wb_req_i.adr == OFS_POP && s_q.cnt != '0) begin
            s_d.rp = s_q.rp + 1'b1;
            s_d.cnt = s_d.cnt - 1'b1;
            if (s_q.ls_en) begin
                s_d.ls_val = {s_q.fifo[s_q.rp], 4'h0};
            end
        end
        // hardware starts, only taken while idle
        if (s_q.hw_en && !busy) begin
            if (s_q.src == SRC_PIN && pin_edge) begin
                go = 1'b1;
            end
            if (s_q.src == SRC_PWM && pwm_trig_i && !s_q.drun) begin
                if (s_q.dly == 8'h00) begin
                    go = 1'b1;
                end else begin
                    s_d.dcnt = s_q.dly;
                    s_d.drun = 1'b1;
                end
            end
            if (s_q.drun) begin
                s_d.dcnt = s_q.dcnt - 8'h01;
                if (s_q.dcnt == 8'h01) begin
                    s_d.drun = 1'b0;
                    go = 1'b1;
                end
            end
        end
        // conversion sequencer
        case (s_q.st)
            ST_IDLE: begin
                if (go && first_ch != 4'hF) begin
                    s_d.start = 1'b1;
                    s_d.ch = first_ch;
                    s_d.second = 1'b0;
                    s_d.smp = 2'h0;
                    s_d.st = ST_SAMPLE;
                end else if (go) begin
                    s_d.start = 1'b0; // nothing enabled: nothing to convert
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    s_d.smp = s_q.smp + 2'h1;
                    if (s_q.smp == 2'(SAMPLE_TICKS - 1)) begin
                        s_d.st = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                if (sar_done_i) begin
                    if (s_q.seq_en && !s_q.one_ch && !s_q.second) begin
                        s_d.second = 1'b1;
                        s_d.ch = pair_ch(s_q.pair, 1'b1);
                        s_d.smp = 2'h0;
                        s_d.st = ST_SAMPLE;
                    end else begin
                        s_d.start = 1'b0;
                        s_d.done_f = 1'b1;
                        s_d.st = ST_IDLE;
                    end
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        // an abort written with a done wins for state; the done flag set above stays
        if (wr && wb_req_i.adr == OFS_CTL && !wv[CTL_START]) begin
            s_d.st = ST_IDLE;
            s_d.start = 1'b0;
        end
        // result storage, after the read effects so a new result wins
        if (res_take) begin
            if (s_q.seq_en && !s_q.one_ch) begin
                if (s_q.second) begin
                    s_d.seq2 = sar_result_i;
                end else begin
                    s_d.seq1 = sar_result_i;
                end
            end
            if (s_q.fifo_en) begin
                if (s_q.cnt != (AW+1)'(DEPTH)) begin
                    s_d.fifo[s_q.wp] = sar_result_i;
                    s_d.wp = s_q.wp + 1'b1;
                    s_d.cnt = s_d.cnt + 1'b1;
                end else begin
                    s_d.ovr = 1'b1; // full fifo drops the result
                end
            end else begin
                s_d.ovr = s_q.vld && s_d.vld;
                s_d.res = sar_result_i;
                s_d.vld = 1'b1;
                if (s_q.ls_en) begin
                    s_d.ls_val = {sar_result_i, 4'h0};
                end
            end
            // compare monitors
            for (int m = 0; m < 2; m++) begin
                if (s_q.cmp[m].ch == s_q.ch) begin
                    if ((sar_result_i >= s_q.cmp[m].thr) == s_q.cmp[m].cond) begin
                        if (s_q.mrun[m] != {1'b0, s_q.cmp[m].mcnt} + 5'h01) begin
                            s_d.mrun[m] = s_q.mrun[m] + 5'h01;
                        end
                        if (s_q.mrun[m] + 5'h01 >= {1'b0, s_q.cmp[m].mcnt} + 5'h01) begin
                            s_d.cmp_f[m] = 1'b1;
                        end
                    end else begin
                        s_d.mrun[m] = 5'h00;
                    end
                end
            end
        end
    end
    // all state in one register, frozen while clock enable is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign sar_o = '{sclk: s_q.sclk, sample: s_q.st == ST_SAMPLE, convert: s_q.st == ST_CONVERT,
                     channel: s_q.ch};
    assign irq_o = (s_q.done_f && s_q.irq_en) || (s_q.cmp_f[0] && s_q.cmp[0].ie)
                   || (s_q.cmp_f[1] && s_q.cmp[1].ie);
    assign dma_req_o = s_q.fifo_en && s_q.dma_en && (s_q.cnt >= (AW+1)'(DMA_LEVEL));
    sequence s_access;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && ce_i;
    endsequence
    property p_ack;
        @(posedge clk_i) disable iff (rst_i) s_access |=> wb_ack_o ##1 !wb_ack_o || !ce_i;
    endproperty
    a_ack: assert property (p_ack) else $error("wishbone ack not one cycle after request");
    property p_irq;
        @(posedge clk_i) disable iff (rst_i) (ce_i && res_take && !(s_q.seq_en && !s_q.one_ch && !s_q.second))
            |=> s_q.done_f && (irq_o || !s_q.irq_en);
    endproperty
    a_irq: assert property (p_irq) else $error("finished conversion left no flag or interrupt");
    property p_dma;
        @(posedge clk_i) disable iff (rst_i) dma_req_o |-> s_q.cnt >= (AW+1)'(DMA_LEVEL) && s_q.fifo_en;
    endproperty
    a_dma: assert property (p_dma) else $error("dma request below half full");
    property p_busy;
        @(posedge clk_i) disable iff (rst_i) busy |-> s_q.start;
    endproperty
    a_busy: assert property (p_busy) else $error("start bit low during conversion");
    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && wr && wb_req_i.adr == OFS_CTL && !wv[CTL_START]) |=> !busy && !s_q.start;
    endproperty
    a_abort: assert property (p_abort) else $error("clear of start bit did not abort");
    property p_tick;
        @(posedge clk_i) disable iff (rst_i || !ce_i) tick |=> !tick [*3];
    endproperty
    a_tick: assert property (p_tick) else $error("adc clock above its cap");
    property p_sample;
        @(posedge clk_i) disable iff (rst_i)
            (s_q.st == ST_CONVERT && $past(s_q.st) == ST_SAMPLE) |-> $past(s_q.smp) == 2'(SAMPLE_TICKS - 1);
    endproperty
    a_sample: assert property (p_sample) else $error("sample window not four adc clocks");
    sequence s_pin_high;
        $past(external_start_pin_i, 1) && $past(external_start_pin_i, 2)
            && $past(external_start_pin_i, 3) && $past(external_start_pin_i, 4);
    endsequence
    property p_glitch;
        @(posedge clk_i) disable iff (rst_i || !ce_i) $rose(s_q.filt) |-> s_pin_high;
    endproperty
    a_glitch: assert property (p_glitch) else $error("pin accepted before four stable clocks");
    property p_single;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && !busy && go && first_ch != 4'hF && !s_q.seq_en) |=> s_q.ch == lowest($past(s_q.chen));
    endproperty
    a_single: assert property (p_single) else $error("single mode picked wrong channel");
    property p_store;
        @(posedge clk_i) disable iff (rst_i) (ce_i && res_take && !s_q.fifo_en) |=> s_q.vld;
    endproperty
    a_store: assert property (p_store) else $error("result not stored in data register");
endmodule
`default_nettype wire

//--- dv/sadc_sar_model.sv
/*
 * behavioural sar core: answers each convert request with a done pulse and a result.
 * assumes the controller holds the channel stable while convert is high.
 */
`timescale 1ns/1ps
`default_nettype none
module sadc_sar_model (
    input wire logic clk_i,
    input wire sadc_pkg::sadc_sar_req_t sar_i,
    input wire logic [7:0] base_i,
    output logic done_o,
    output logic [11:0] result_o
);
    import sadc_pkg::*;
    // latency varies so that prompt and slow answers both occur
    initial begin
        done_o = 1'b0;
        result_o = 12'h000;
        forever begin
            @(posedge clk_i);
            if (sar_i.convert === 1'b1) begin
                repeat ($urandom_range(6, 0)) @(posedge clk_i);
                done_o <= 1'b1;
                result_o <= {base_i, sar_i.channel};
                @(posedge clk_i);
                done_o <= 1'b0;
                // data is not held after done: show the inverse, never the old value
                result_o <= ~result_o;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
/*
 * self-checking bench of the converter controller: wishbone master, pin and pwm starts.
 * assumes the design answers every bus request one cycle after taking it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sadc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic pin = 1'b0;
    logic pwm = 1'b0;
    logic done, ack, irq, dma;
    logic [11:0] res, r;
    logic [7:0] base = 8'h00;
    logic [31:0] rdat;
    sadc_wb_req_t req = '0;
    sadc_sar_req_t sar;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    int n, d;
    int chs[4] = '{0, 7, 8, 10};
    logic [31:0] eq[$], mq[$], fq[$];

    sadc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_ack_o(ack),
        .wb_dat_o(rdat), .external_start_pin_i(pin), .pwm_trig_i(pwm), .sar_done_i(done),
        .sar_result_i(res), .sar_o(sar), .irq_o(irq), .dma_req_o(dma));
    sadc_sar_model core (.clk_i(clk_i), .sar_i(sar), .base_i(base), .done_o(done), .result_o(res));

    initial forever #4 clk_i = ~clk_i;

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // one classic cycle: hold everything until ack is sampled, then release
    task bus(input logic [7:0] a, input logic [31:0] dt, input logic w);
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: dt};
        do @(posedge clk_i); while (ack !== 1'b1);
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] dt);
        bus(a, dt, 1'b1);
    endtask

    // the expectation is queued; the watcher below compares when the answer shows
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        eq.push_back(e & m);
        mq.push_back(m);
        bus(a, 32'h0000_0000, 1'b0);
    endtask

    task conv(input int k);
        repeat (k) begin
            @(posedge sar.convert);
            @(negedge sar.convert);
        end
        repeat (4) @(posedge clk_i);
    endtask

    task fin(input string s);
        $display("test %s done", s);
    endtask

    // read answers are taken at the ack edge, while the request still stands
    always @(posedge clk_i) begin
        if (ack === 1'b1 && req.we === 1'b0 && eq.size() > 0) chk(eq.pop_front(), rdat & mq.pop_front());
    end

    // hang guard: roughly a thousand cycles are expected, the ceiling is far above
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop;
        end
    end

    initial begin
        void'($urandom(32'ha16e8ba9));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_CTL, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(OFS_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'hFC, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(OFS_CTL2, 32'h0000_0300);
        // shifted view is captured as results land, so it is switched on first
        wr(OFS_LS, 32'h0000_0001);
        fin("reset");
        // single mode, lowest enabled channel wins; monitor 0 matches, monitor 1 not
        foreach (chs[i]) begin
            r = {8'($urandom), 4'(chs[i])};
            base <= r[11:4];
            wr(OFS_CMP0, {4'h0, r, 9'h000, 4'(chs[i]), 3'h5});
            wr(OFS_CMP1, {4'h0, r, 9'h000, 4'(chs[i]), 3'h0});
            wr(OFS_CHEN, 32'h0000_0400 | (32'h0000_0001 << chs[i]));
            wr(OFS_CTL, 32'h0000_0802);
            rd(OFS_CTL, 32'h0000_0800, 32'h0000_0800);
            conv(1);
            rd(OFS_CTL, 32'h0000_0000, 32'h0000_0800);
            rd(OFS_DATA, {14'h0000, 2'h2, 4'h0, r}, 32'h0003_FFFF);
            rd(OFS_DATA, 32'h0000_0000, 32'h0002_0000);
            rd(OFS_STAT, 32'h0000_0003, 32'h0000_000F);
            chk(32'h0000_0001, {31'h0, irq});
            wr(OFS_STAT, 32'h0000_0007);
            chk(32'h0000_0000, {31'h0, irq});
        end
        rd(OFS_LS, {r, 20'h0_0000}, 32'hFFFF_0000);
        wr(OFS_LS, 32'h0000_0000);
        fin("single");
        // clearing the start bit in mid-sample must drop back to idle
        wr(OFS_CTL, 32'h0000_0800);
        wr(OFS_CTL, 32'h0000_0000);
        rd(OFS_STAT, 32'h0000_0000, 32'h0000_0008);
        chk(32'h0000_0000, {31'h0, sar.sample | sar.convert});
        fin("abort");
        wr(OFS_SEQ, 32'h0000_0009);
        wr(OFS_CTL, 32'h0000_0800);
        // a low clock enable must hold the sample window where it stands
        ce_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        ce_i <= 1'b1;
        chk(32'h0000_0001, {31'h0, sar.sample});
        conv(2);
        rd(OFS_SEQ1, {20'h0_0000, r[11:4], 4'h0}, 32'h0000_0FFF);
        rd(OFS_SEQ2, {20'h0_0000, r[11:4], 4'h2}, 32'h0000_0FFF);
        wr(OFS_SEQ, 32'h0000_0000);
        fin("shunt");
        // pin: a two-cycle glitch is ignored, a held rising then falling edge starts
        wr(OFS_CHEN, 32'h0000_0010);
        wr(OFS_CTL, 32'h0000_0140);
        pin <= 1'b1;
        repeat (2) @(posedge clk_i);
        pin <= 1'b0;
        repeat (8) @(posedge clk_i);
        rd(OFS_STAT, 32'h0000_0000, 32'h0000_0008);
        pin <= 1'b1;
        conv(1);
        rd(OFS_DATA, {14'h0000, 2'h2, 4'h0, r[11:4], 4'h4}, 32'h0002_0FFF);
        wr(OFS_CTL, 32'h0000_0100);
        pin <= 1'b0;
        conv(1);
        rd(OFS_DATA, {14'h0000, 2'h2, 4'h0, r[11:4], 4'h4}, 32'h0002_0FFF);
        fin("pin");
        // pwm sequence on channel 6 into the fifo, dma at eight entries
        wr(OFS_FCTL, 32'h0000_0003);
        wr(OFS_SEQ, 32'h0000_060F);
        wr(OFS_CTL, 32'h0000_0130);
        for (int k = 0; k < 8; k++) begin
            d = $urandom_range(15, 0);
            r = {8'($urandom), 4'h6};
            base <= r[11:4];
            fq.push_back({20'h0_0000, r});
            wr(OFS_DLY, 32'(d));
            pwm <= 1'b1;
            @(posedge clk_i);
            pwm <= 1'b0;
            n = 0;
            while (sar.sample !== 1'b1) begin
                @(negedge clk_i);
                n++;
            end
            chk(32'h0000_0001, {31'h0, n >= d + 1 && n <= d + 3});
            conv(1);
            chk({31'h0, k == 7}, {31'h0, dma});
        end
        while (fq.size() > 0) rd(OFS_POP, fq.pop_front(), 32'h0000_0FFF);
        chk(32'h0000_0000, {31'h0, dma});
        fin("pwm");
        report_and_stop;
    end
endmodule
`default_nettype wire
